// *** fram_consts.vh ***
`ifndef FRAM_CONSTS_VH
`define FRAM_CONSTS_VH
// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define OP_SET_LATCH 8'h06
`define OP_CLEAR_LATCH 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_WRITE 8'h02
// ---------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------
`define ST_LATCH_BIT 1
`define ST_GUARD_LO_BIT 2
`define ST_GUARD_HI_BIT 3
`define ST_FIXED_ONE_BIT 6
`define ST_PIN_EN_BIT 7
`define ST_RESET_GUARD 2'h0
`define ST_RESET_PIN_EN 1'h0
`define ST_IDLE_BYTE 8'h40
// ---------------------------------------------------------------
// Frame counts
// ---------------------------------------------------------------
`define BITS_LAST 3'h7
`define ADDR_BYTES_LAST 2'h2
// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define ADDR_BITS 20
`define ADDR_LAST 20'hfffff
`define ADDR_QUARTER 20'hc0000
`define ADDR_HALF 20'h80000
`define ADDR_ZERO 20'h00000
`endif

// *** pin_sync.v ***
`timescale 1ns/1ps
module pin_sync #(
	parameter [0:0] RESET_LEVEL = 1'b0 // Idle level of the pin
) (
	input wire clk_in, // System clock
	input wire reset_n_in, // Async reset, active low
	input wire pin_in, // Raw pin
	output reg level_out // Filtered level
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s1 <= RESET_LEVEL;
			s2 <= RESET_LEVEL;
			s3 <= RESET_LEVEL;
			level_out <= RESET_LEVEL;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_out <= s3;
		end
	end
endmodule

// *** fram_status_write.v ***
// Notes on behaviour
// - Status bits 0,4,5 read zero, bit 6 reads one; writes ignored.
// - Write latch flag sits in bit 1, cleared at power-up.
// - Status write clears latch at select rise; memory write and set/clear change it too.
// - Block guard bits 2 and 3 are retained across power loss.
// - Guard 00 none, 01 from C0000h, 10 from 80000h, 11 everything.
// - Pin enable bit 7 zero ignores pin; one with pin low blocks status write.
// - Only guard bits and latch gate array writes; clear latch blocks all.
// - Protect pin never blocks array writes.
// - Opcode 05h shifts out the status byte, repeated while clocks continue.
// - Completed status write clears the latch.
// - Write 02h takes three address bytes; low 20 bits used.
// - Data stored at successive addresses, wrapping FFFFFh to 00000h.
// - Byte shifted MSB first, committed right after its eighth clock.
// - Chip select rising ends a memory write.
// - Reaching a protected address freezes address, drops later bytes.
// - Partial bytes are never stored.
// - Opcode 06h sets latch, 04h clears it.
// - Latch clears at select rise after clear, status write, memory write.
// - First byte after select falls is the opcode.
// - Unknown opcode: ignore input until next select fall, output off.
`timescale 1ns/1ps
`include "fram_consts.vh"
module fram_status_write #(
	parameter ADDR_W = `ADDR_BITS // Array address width
) (
	input wire clk_in, // System clock, 200 MHz
	input wire reset_n_in, // Async reset, active low (power-up)
	input wire sel_n_in, // Chip select pin, active low
	input wire sck_in, // Serial clock pin
	input wire sdi_in, // Serial data in pin
	input wire guard_pin_n_in, // Protect pin, active low
	input wire [1:0] guard_boot_in, // Retained guard bits at power-up
	input wire pin_en_boot_in, // Retained pin enable at power-up
	output reg sdo_out, // Serial data out
	output reg sdo_oe_out, // Serial data out enable
	output reg mem_we_out, // Array write strobe, one cycle
	output reg [ADDR_W-1:0] mem_addr_out, // Array write address
	output reg [7:0] mem_data_out, // Array write data
	output reg [7:0] status_out, // Status register view
	output reg nv_we_out // Retained bits updated, one cycle
);
	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	localparam S_OPC = 3'h0;
	localparam S_RDST = 3'h1;
	localparam S_WRST = 3'h2;
	localparam S_ADDR = 3'h3;
	localparam S_DATA = 3'h4;
	localparam S_IGN = 3'h5;
	localparam S_DONE = 3'h6;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	wire sel_n;
	wire sck;
	wire sdi;
	wire wp_n;
	pin_sync #(
		.RESET_LEVEL(1'b1)
	) u_sel (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.pin_in(sel_n_in),
		.level_out(sel_n)
	);

	pin_sync #(
		.RESET_LEVEL(1'b0)
	) u_sck (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.pin_in(sck_in),
		.level_out(sck)
	);

	pin_sync #(
		.RESET_LEVEL(1'b0)
	) u_sdi (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.pin_in(sdi_in),
		.level_out(sdi)
	);

	pin_sync #(
		.RESET_LEVEL(1'b1)
	) u_wp (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.pin_in(guard_pin_n_in),
		.level_out(wp_n)
	);

	// ---------------------------------------------------------------
	// Protection decode
	// ---------------------------------------------------------------
	function guarded;
		input [1:0] g;
		input [ADDR_W-1:0] a;
		begin
			case (g)
			2'b00: guarded = 1'b0;
			2'b01: guarded = (a >= `ADDR_QUARTER);
			2'b10: guarded = (a >= `ADDR_HALF);
			default: guarded = 1'b1;
			endcase
		end
	endfunction

	function [7:0] status_byte;
		input pe;
		input [1:0] g;
		input wl;
		begin
			status_byte = 8'h00;
			status_byte[`ST_FIXED_ONE_BIT] = 1'b1;
			status_byte[`ST_PIN_EN_BIT] = pe;
			status_byte[`ST_GUARD_HI_BIT] = g[1];
			status_byte[`ST_GUARD_LO_BIT] = g[0];
			status_byte[`ST_LATCH_BIT] = wl;
		end
	endfunction

	// ---------------------------------------------------------------
	// Address step
	// ---------------------------------------------------------------
	function [ADDR_W-1:0] next_addr;
		input [ADDR_W-1:0] a;
		begin
			if (a == `ADDR_LAST)
				next_addr = `ADDR_ZERO;
			else
				next_addr = a + {{(ADDR_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// ---------------------------------------------------------------
	// Latch decode
	// ---------------------------------------------------------------
	function clears_latch;
		input [7:0] op;
		begin
			case (op)
			`OP_CLEAR_LATCH: clears_latch = 1'b1;
			`OP_STATUS_WRITE: clears_latch = 1'b1;
			`OP_MEM_WRITE: clears_latch = 1'b1;
			default: clears_latch = 1'b0;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Frame engine
	// ---------------------------------------------------------------
	reg sck_d;
	reg sel_d;
	reg boot_done;
	reg [2:0] state;
	reg [2:0] bit_cnt;
	reg [7:0] shift;
	reg [1:0] addr_cnt;
	reg [ADDR_W-1:0] addr;
	reg stopped;
	reg [7:0] out_sh;
	reg [7:0] last_op;
	reg write_latch_flag;
	reg [1:0] block_guard;
	reg guard_pin_enable;

	// ---------------------------------------------------------------
	// Pin edges
	// ---------------------------------------------------------------
	wire rise = sck & ~sck_d;
	wire fall = ~sck & sck_d;
	wire sel_fall = ~sel_n & sel_d;
	wire sel_rise = sel_n & ~sel_d;
	wire [7:0] byte_in = {shift[6:0], sdi};
	wire byte_done = rise & ~sel_n & (bit_cnt == `BITS_LAST);

	// ---------------------------------------------------------------
	// Write permission
	// ---------------------------------------------------------------
	reg status_write_ok;
	reg array_write_ok;
	always @* begin
		status_write_ok = write_latch_flag;
		if (guard_pin_enable && !wp_n)
			status_write_ok = 1'b0;
		array_write_ok = write_latch_flag;
		if (guarded(block_guard, addr))
			array_write_ok = 1'b0;
	end

	// ---------------------------------------------------------------
	// Edge detectors
	// ---------------------------------------------------------------
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sck_d <= 1'b0;
			sel_d <= 1'b1;
		end else begin
			sck_d <= sck;
			sel_d <= sel_n;
		end
	end

	// ---------------------------------------------------------------
	// Command engine
	// ---------------------------------------------------------------
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			boot_done <= 1'b0;
			state <= S_OPC;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			addr_cnt <= 2'h0;
			addr <= {ADDR_W{1'b0}};
			stopped <= 1'b0;
			out_sh <= 8'h00;
			last_op <= 8'h00;
			write_latch_flag <= 1'b0;
			block_guard <= `ST_RESET_GUARD;
			guard_pin_enable <= `ST_RESET_PIN_EN;
			sdo_out <= 1'b0;
			sdo_oe_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_addr_out <= {ADDR_W{1'b0}};
			mem_data_out <= 8'h00;
			nv_we_out <= 1'b0;
		end else begin
			mem_we_out <= 1'b0;
			nv_we_out <= 1'b0;
			if (!boot_done) begin
				boot_done <= 1'b1;
				block_guard <= guard_boot_in;
				guard_pin_enable <= pin_en_boot_in;
			end
			if (sel_fall) begin
				state <= S_OPC;
				bit_cnt <= 3'h0;
				stopped <= 1'b0;
				last_op <= 8'h00;
			end else if (sel_rise) begin
				sdo_oe_out <= 1'b0;
				state <= S_OPC;
				bit_cnt <= 3'h0;
				if (clears_latch(last_op))
					write_latch_flag <= 1'b0;
			end else if (!sel_n) begin
				if (fall && state == S_RDST) begin
					sdo_oe_out <= 1'b1;
					sdo_out <= out_sh[7];
					out_sh <= {out_sh[6:0], 1'b0};
				end
				if (rise && state != S_IGN && state != S_DONE) begin
					shift <= byte_in;
					bit_cnt <= bit_cnt + 3'h1;
				end
				if (byte_done) begin
					case (state)
					S_OPC: begin
						case (byte_in)
						`OP_SET_LATCH: begin
							write_latch_flag <= 1'b1;
							state <= S_DONE;
						end
						`OP_CLEAR_LATCH: begin
							last_op <= byte_in;
							state <= S_DONE;
						end
						`OP_STATUS_READ: begin
							out_sh <= status_byte(guard_pin_enable,
								block_guard, write_latch_flag);
							state <= S_RDST;
						end
						`OP_STATUS_WRITE: begin
							last_op <= byte_in;
							sdo_oe_out <= 1'b0;
							state <= S_WRST;
						end
						`OP_MEM_WRITE: begin
							last_op <= byte_in;
							addr_cnt <= 2'h0;
							sdo_oe_out <= 1'b0;
							state <= S_ADDR;
						end
						default: begin
							sdo_oe_out <= 1'b0;
							state <= S_IGN;
						end
						endcase
					end
					S_RDST: begin
						out_sh <= status_byte(guard_pin_enable,
							block_guard, write_latch_flag);
					end
					S_WRST: begin
						state <= S_DONE;
						if (status_write_ok) begin
							guard_pin_enable <= byte_in[`ST_PIN_EN_BIT];
							block_guard <= {byte_in[`ST_GUARD_HI_BIT],
								byte_in[`ST_GUARD_LO_BIT]};
							nv_we_out <= 1'b1;
						end
					end
					S_ADDR: begin
						addr <= {addr[ADDR_W-9:0], byte_in};
						addr_cnt <= addr_cnt + 2'h1;
						if (addr_cnt == `ADDR_BYTES_LAST)
							state <= S_DATA;
					end
					S_DATA: begin
						if (stopped || !array_write_ok) begin
							stopped <= 1'b1;
						end else begin
							mem_we_out <= 1'b1;
							mem_addr_out <= addr;
							mem_data_out <= byte_in;
							addr <= next_addr(addr);
						end
					end
					default: state <= state;
					endcase
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Status view
	// ---------------------------------------------------------------
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			status_out <= `ST_IDLE_BYTE;
		else
			status_out <= status_byte(guard_pin_enable, block_guard,
				write_latch_flag);
	end
endmodule

// *** fram_status_write_asserts.sv ***
`timescale 1ns/1ps
module fram_status_write_asserts #(
	parameter ADDR_W = 20
) (
	input wire clk_in, // Clock
	input wire reset_n_in, // Reset
	input wire sel_n_in, // Select
	input wire sck_in, // Sck
	input wire sdi_in, // Sdi
	input wire guard_pin_n_in, // Pin
	input wire [1:0] guard_boot_in, // Boot
	input wire pin_en_boot_in, // Boot
	input wire sdo_out, // Sdo
	input wire sdo_oe_out, // Oe
	input wire mem_we_out, // Strobe
	input wire [ADDR_W-1:0] mem_addr_out, // Addr
	input wire [7:0] mem_data_out, // Data
	input wire [7:0] status_out, // Status
	input wire nv_we_out // Update
);
default clocking @(posedge clk_in); endclocking
default disable iff (!reset_n_in);
reg arm;
reg [ADDR_W-1:0] nxt;
function automatic logic prot(input logic [ADDR_W-1:0] a,
	input logic [1:0] g);
	prot = g == 2'h3 || (g == 2'h2 && a[ADDR_W-1]) ||
		(g == 2'h1 && a[ADDR_W-1 -: 2] == 2'h3);
endfunction
// Next expected address within one frame
always @(posedge clk_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		arm <= 1'b0;
		nxt <= {ADDR_W{1'b0}};
	end else if (sel_n_in) begin
		arm <= 1'b0;
	end else if (mem_we_out) begin
		arm <= 1'b1;
		nxt <= mem_addr_out + 1'b1;
	end
end
a_fixed_bits: assert property (
	status_out[6] && status_out[5:4] == 2'h0 && !status_out[0])
	else $error("fixed status bits wrong");
a_out_idle: assert property (
	sel_n_in [*8] |-> !sdo_oe_out) else $error("sdo driven when idle");
a_we_latch: assert property (
	mem_we_out |-> status_out[1]) else $error("write with latch clear");
a_we_guard: assert property (
	mem_we_out |-> !prot(mem_addr_out, status_out[3:2]))
	else $error("write into guarded block");
a_we_pulse: assert property (
	mem_we_out |=> !mem_we_out) else $error("strobe too long");
a_nv_pin: assert property (
	nv_we_out |-> guard_pin_n_in || !status_out[7])
	else $error("status write while pin guards");
a_latch_drop: assert property (
	$fell(status_out[1]) |-> sel_n_in) else $error("latch cleared in frame");
a_addr_step: assert property (
	mem_we_out && arm |-> mem_addr_out == nxt) else $error("address skip");
c_mem: cover property (mem_we_out);
c_nv: cover property (nv_we_out);
c_read: cover property (sdo_oe_out);
endmodule
bind fram_status_write fram_status_write_asserts #(.ADDR_W(ADDR_W)) a_i (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .sel_n_in(sel_n_in),
	.sck_in(sck_in), .sdi_in(sdi_in), .guard_pin_n_in(guard_pin_n_in),
	.guard_boot_in(guard_boot_in), .pin_en_boot_in(pin_en_boot_in),
	.sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .mem_we_out(mem_we_out),
	.mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
	.status_out(status_out), .nv_we_out(nv_we_out));

// *** spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
	output logic sel_n_out, // Select
	output logic sck_out, // Clock, idle low
	output logic sdi_out, // Data out
	input wire sdo_in // Data in
);
initial begin
	sel_n_out = 1'b1;
	sck_out = 1'b0;
	sdi_out = 1'b0;
end
task start;
	#100 sel_n_out = 1'b0;
endtask
task stop;
	#100 sel_n_out = 1'b1;
	sdi_out = ~sdi_out;
	#400;
endtask
// MSB first, device samples on the rise
task xfer(input logic [7:0] b, input int n, output logic [7:0] r);
	for (int i = 7; i > 7 - n; i--) begin
		sdi_out = b[i];
		#80 sck_out = 1'b1;
		r[i] = sdo_in;
		#80 sck_out = 1'b0;
	end
	sdi_out = ~sdi_out;
endtask
endmodule

// *** fram_status_write_bench.sv ***
`timescale 1ns/1ps
`include "fram_consts.vh"
module fram_status_write_bench;
logic clk_in = 1'b0;
logic reset_n_in = 1'b0;
logic guard_pin_n_in = 1'b1;
logic [1:0] guard_boot_in = 2'b01;
logic pin_en_boot_in = 1'b0;
wire sel_n, sck, sdi, sdo_out, sdo_oe_out, mem_we_out, nv_we_out;
wire [19:0] mem_addr_out;
wire [7:0] mem_data_out, status_out;
wire sdo_w = sdo_oe_out ? sdo_out : 1'bz;
int failures = 0;
int n_tests = 0;
int nv_cnt = 0;
logic [27:0] seen[$];
logic [7:0] r;
initial begin
	forever #2.5 clk_in = ~clk_in;
end
fram_status_write fram_status_write_i (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .sel_n_in(sel_n), .sck_in(sck), .sdi_in(sdi),
	.guard_pin_n_in(guard_pin_n_in), .guard_boot_in(guard_boot_in),
	.pin_en_boot_in(pin_en_boot_in), .sdo_out(sdo_out),
	.sdo_oe_out(sdo_oe_out), .mem_we_out(mem_we_out),
	.mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
	.status_out(status_out), .nv_we_out(nv_we_out));
spi_host_model spi_host_model_i (.sel_n_out(sel_n), .sck_out(sck),
	.sdi_out(sdi), .sdo_in(sdo_w));
always @(posedge clk_in) begin
	if (mem_we_out === 1'b1)
		seen.push_back({mem_addr_out, mem_data_out});
	if (nv_we_out === 1'b1)
		nv_cnt++;
end
task chk(input logic [27:0] s, input logic [27:0] e);
	n_tests++;
	if (s !== e) begin
		failures++;
		$display("wrong value at %0t: got %h want %h", $time, s, e);
	end
endtask
task give_verdict;
	$display("checks %0d mismatches %0d", n_tests, failures);
	if (failures == 0 && n_tests > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task send(input logic [7:0] q[$], input int part);
	@(posedge clk_in) #1 spi_host_model_i.start;
	foreach (q[i])
		spi_host_model_i.xfer(q[i], 8, r);
	if (part > 0)
		spi_host_model_i.xfer(8'h5a, part, r);
	spi_host_model_i.stop;
endtask
task status_read_cmd(input logic [7:0] e);
	send('{`OP_STATUS_READ, 8'h00}, 0);
	chk({20'h0, r}, {20'h0, e});
	chk({20'h0, status_out}, {20'h0, e});
endtask
task wr(input logic [27:0] e[$]);
	chk(28'(seen.size()), 28'(e.size()));
	foreach (e[i])
		chk(seen[i], e[i]);
	seen.delete();
endtask
task latch;
	send('{`OP_SET_LATCH}, 0);
endtask
initial begin
	repeat (16) @(posedge clk_in);
	#1 reset_n_in = 1'b1;
	repeat (20) @(posedge clk_in);
	status_read_cmd(8'h44);
	send('{`OP_MEM_WRITE, 8'h00, 8'h00, 8'h10, 8'h99}, 0);
	chk(28'(seen.size()), 28'h0);
	latch;
	status_read_cmd(8'h46);
	send('{`OP_CLEAR_LATCH}, 0);
	status_read_cmd(8'h44);
	latch;
	send('{`OP_MEM_WRITE, 8'hfb, 8'hff, 8'hfe, 8'h11, 8'h22, 8'h33}, 0);
	wr('{28'hbfffe11, 28'hbffff22});
	latch;
	send('{`OP_STATUS_WRITE, 8'h82}, 0);
	status_read_cmd(8'hc0);
	@(posedge clk_in) #1 guard_pin_n_in = 1'b0;
	latch;
	send('{`OP_MEM_WRITE, 8'h0f, 8'hff, 8'hff, 8'h44, 8'h55}, 3);
	wr('{28'hfffff44, 28'h0000055});
	latch;
	send('{`OP_STATUS_WRITE, 8'h0c}, 0);
	status_read_cmd(8'hc0);
	@(posedge clk_in) #1 guard_pin_n_in = 1'b1;
	latch;
	send('{`OP_STATUS_WRITE, 8'h0c}, 0);
	status_read_cmd(8'h4c);
	latch;
	send('{`OP_MEM_WRITE, 8'h00, 8'h00, 8'h00, 8'h77}, 0);
	chk(28'(seen.size()), 28'h0);
	send('{8'h77, `OP_SET_LATCH}, 0);
	status_read_cmd(8'h4c);
	chk(28'(nv_cnt), 28'h2);
	give_verdict;
end
initial begin
	#200000;
	failures++;
	give_verdict;
end
endmodule
